// ===== adcsc_pkg.sv
package adcsc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADCSC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADCSC_ADDR_RESULT = 8'h04;
  localparam logic [7:0] ADCSC_ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADCSC_ADDR_CLR    = 8'h0C;
  localparam logic [7:0] ADCSC_ADDR_ENA    = 8'h10;

  // adc_control_one field positions
  localparam int ADCSC_BIT_DONE      = 0;
  localparam int ADCSC_BIT_SAMPLING  = 1;
  localparam int ADCSC_BIT_AUTOSTART = 2;
  localparam int ADCSC_BIT_STOPIRQ   = 4;
  localparam int ADCSC_TRIGSRC_LO    = 5;
  localparam int ADCSC_TRIGSRC_W     = 3;
  localparam int ADCSC_BIT_ON        = 15;

  // Conversion trigger source encodings
  localparam logic [2:0] ADCSC_TRIG_SW   = 3'h0;
  localparam logic [2:0] ADCSC_TRIG_PIN  = 3'h1;
  localparam logic [2:0] ADCSC_TRIG_AUTO = 3'h7;

  // Interrupt status bits
  localparam int ADCSC_IRQ_W        = 2;
  localparam int ADCSC_IRQ_DONE     = 0;
  localparam int ADCSC_IRQ_AUTOSTOP = 1;

  // Result width and reset values
  localparam int          ADCSC_RES_W      = 10;
  localparam logic [31:0] ADCSC_RESET_WORD = 32'h0000_0000;

  // Internal sample timer, least time rounded up to whole cycles
  localparam int ADCSC_CLK_PERIOD_PS  = 8000;
  localparam int ADCSC_SAMPLE_TIME_NS = 1000;
  localparam int ADCSC_SAMPLE_CYC     =
    (ADCSC_SAMPLE_TIME_NS * 1000 + ADCSC_CLK_PERIOD_PS - 1) / ADCSC_CLK_PERIOD_PS;
  localparam int ADCSC_CNT_W          = 8;

  typedef enum logic [1:0] {
    ADCSC_ST_IDLE    = 2'b00,
    ADCSC_ST_SAMPLE  = 2'b01,
    ADCSC_ST_CONVERT = 2'b10
  } adcsc_state_t;

endpackage : adcsc_pkg

// ===== adcsc_top.sv
// What this block does
// [RULE1] Stop option clears auto-start at interrupt
// [RULE2] Without stop option, results keep overwriting buffer
// [RULE3] Auto-start resamples after conversion, sets flag
// [RULE4] Without auto-start, writing one starts sampling
// [RULE5] Software source: writing zero starts conversion
// [RULE6] Other sources end sampling in hardware
// [RULE7] Sample flag shows acquire versus hold
// [RULE8] Done flag set when conversion completes
// [RULE9] Done cleared by writing zero, harmless
// [RULE10] Done cleared when a conversion starts
// [RULE11] Software avoids access right after turn-off
// [RULE12] Interrupt event raised together with done
`timescale 1ns/10ps
`default_nettype none

module adcsc_top
  import adcsc_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   trigger_pin,
  input  wire logic                   conv_complete,
  input  wire logic [ADCSC_RES_W-1:0] conv_result,
  output logic                        sample_hold,
  output logic                        conv_start,
  output logic                        interrupt
);

  adcsc_state_t                 state_r;
  adcsc_state_t                 state_nxt;
  logic                         on_r;
  logic                         autostart_r;
  logic                         stopirq_r;
  logic [ADCSC_TRIGSRC_W-1:0]   trigsrc_r;
  logic                         done_r;
  logic [ADCSC_RES_W-1:0]       result_r;
  logic [ADCSC_IRQ_W-1:0]       irq_stat_r;
  logic [ADCSC_IRQ_W-1:0]       irq_ena_r;
  logic [ADCSC_CNT_W-1:0]       sample_cnt_r;
  logic [2:0]                   trig_sync_r;
  logic [2:0]                   cmpl_sync_r;
  logic                         dph_r;
  logic                         dwrite_r;
  logic [7:0]                   daddr_r;
  logic [31:0]                  hrdata_r;
  logic                         hreadyout_r;
  logic                         sample_hold_r;
  logic                         conv_start_r;
  logic                         interrupt_r;

  // Bus decode
  wire        addr_take = hsel & htrans[1] & hready;
  wire        wr_any    = dph_r & dwrite_r;
  wire        wr_ctrl   = wr_any & (daddr_r == ADCSC_ADDR_CTRL);
  wire        wr_clr    = wr_any & (daddr_r == ADCSC_ADDR_CLR);
  wire        wr_ena    = wr_any & (daddr_r == ADCSC_ADDR_ENA);
  wire        wd_acq    = hwdata[ADCSC_BIT_SAMPLING];
  wire [31:0] ctrl_word = {16'h0000, on_r, 7'h00, trigsrc_r, stopirq_r, 1'b0,
                           autostart_r, sample_hold_r, done_r};
  wire [31:0] rd_mux    =
    (daddr_r == ADCSC_ADDR_CTRL)   ? ctrl_word :
    (daddr_r == ADCSC_ADDR_RESULT) ? {{(32-ADCSC_RES_W){1'b0}}, result_r} :
    (daddr_r == ADCSC_ADDR_STAT)   ? {{(32-ADCSC_IRQ_W){1'b0}}, irq_stat_r} :
    (daddr_r == ADCSC_ADDR_ENA)    ? {{(32-ADCSC_IRQ_W){1'b0}}, irq_ena_r} :
    32'h0000_0000;

  // Sequencing events
  wire in_sample  = (state_r == ADCSC_ST_SAMPLE);
  wire in_convert = (state_r == ADCSC_ST_CONVERT);
  wire trig_rise  = trig_sync_r[1] & ~trig_sync_r[2];
  wire cmpl       = in_convert & cmpl_sync_r[1] & ~cmpl_sync_r[2];
  wire timer_done = (sample_cnt_r == ADCSC_CNT_W'(ADCSC_SAMPLE_CYC - 1));
  wire sw_start   = wr_ctrl & wd_acq & ~autostart_r;                    // [RULE4]
  wire sw_end     = wr_ctrl & ~wd_acq & (trigsrc_r == ADCSC_TRIG_SW);   // [RULE5]
  wire hw_end     = ((trigsrc_r == ADCSC_TRIG_AUTO) & timer_done) |
                    ((trigsrc_r == ADCSC_TRIG_PIN) & trig_rise);        // [RULE6]
  wire start_conv = on_r & in_sample & (sw_end | hw_end);
  wire auto_stop  = cmpl & stopirq_r;
  wire [ADCSC_IRQ_W-1:0] irq_evt = {auto_stop, cmpl};                   // [RULE12]
  // Set beats clear; the line follows status in the same cycle
  wire [ADCSC_IRQ_W-1:0] irq_clr      = wr_clr ? hwdata[ADCSC_IRQ_W-1:0] : '0;
  wire [ADCSC_IRQ_W-1:0] irq_stat_nxt = irq_evt | (irq_stat_r & ~irq_clr);
  wire [ADCSC_IRQ_W-1:0] irq_ena_nxt  = wr_ena ? hwdata[ADCSC_IRQ_W-1:0] : irq_ena_r;

  always_comb
  begin
    state_nxt = state_r;
    if (!on_r)
      state_nxt = ADCSC_ST_IDLE;
    else
      unique case (state_r)
        ADCSC_ST_IDLE:
          if (autostart_r || sw_start)
            state_nxt = ADCSC_ST_SAMPLE;                                // [RULE3] [RULE4]
        ADCSC_ST_SAMPLE:
          if (start_conv)
            state_nxt = ADCSC_ST_CONVERT;                               // [RULE5] [RULE6]
        ADCSC_ST_CONVERT:
          if (cmpl)
            state_nxt = (autostart_r && !stopirq_r) ? ADCSC_ST_SAMPLE   // [RULE3]
                                                    : ADCSC_ST_IDLE;    // [RULE1]
        default:
          state_nxt = ADCSC_ST_IDLE;
      endcase
  end

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trig_sync_r <= 3'h0;
      cmpl_sync_r <= 3'h0;
    end
    else
    begin
      trig_sync_r <= {trig_sync_r[1:0], trigger_pin};
      cmpl_sync_r <= {cmpl_sync_r[1:0], conv_complete};
    end
  end

  // AHB-Lite slave, one wait state so reads see a just-written value
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dph_r       <= 1'b0;
      dwrite_r    <= 1'b0;
      daddr_r     <= 8'h00;
      hrdata_r    <= ADCSC_RESET_WORD;
      hreadyout_r <= 1'b1;
    end
    else
    begin
      dph_r       <= addr_take;
      hreadyout_r <= ~addr_take;
      if (addr_take)
      begin
        dwrite_r <= hwrite;
        daddr_r  <= {haddr[7:2], 2'b00};
      end
      if (dph_r)
        hrdata_r <= rd_mux;
    end
  end

  // Control fields
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      on_r        <= 1'b0;
      autostart_r <= 1'b0;
      stopirq_r   <= 1'b0;
      trigsrc_r   <= ADCSC_TRIG_SW;
    end
    else if (wr_ctrl)
    begin
      on_r        <= hwdata[ADCSC_BIT_ON];
      autostart_r <= hwdata[ADCSC_BIT_AUTOSTART];
      stopirq_r   <= hwdata[ADCSC_BIT_STOPIRQ];
      trigsrc_r   <= hwdata[ADCSC_TRIGSRC_LO +: ADCSC_TRIGSRC_W];
    end
    else if (auto_stop)
      autostart_r <= 1'b0;                                              // [RULE1]
  end

  // Done flag: hardware set beats a software clear
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      done_r <= 1'b0;
    else if (cmpl)
      done_r <= 1'b1;                                                   // [RULE8]
    else if (start_conv)
      done_r <= 1'b0;                                                   // [RULE10]
    else if (wr_ctrl && !hwdata[ADCSC_BIT_DONE])
      done_r <= 1'b0;                                                   // [RULE9]
  end

  // Sequencer, result buffer, timer and pin outputs
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r       <= ADCSC_ST_IDLE;
      result_r      <= '0;
      sample_cnt_r  <= '0;
      sample_hold_r <= 1'b0;
      conv_start_r  <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      sample_hold_r <= (state_nxt == ADCSC_ST_SAMPLE);                  // [RULE7]
      conv_start_r  <= start_conv;
      sample_cnt_r  <= (in_sample && !timer_done) ? sample_cnt_r + 1'b1 : '0;
      if (cmpl)
        result_r <= conv_result;                                        // [RULE2]
    end
  end

  // Interrupt status, enable and line
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_stat_r  <= '0;
      irq_ena_r   <= '0;
      interrupt_r <= 1'b0;
    end
    else
    begin
      irq_stat_r  <= irq_stat_nxt;
      interrupt_r <= |(irq_stat_nxt & irq_ena_nxt);
      if (wr_ena)
        irq_ena_r <= hwdata[ADCSC_IRQ_W-1:0];
    end
  end

  assign hrdata      = hrdata_r;
  assign hreadyout   = hreadyout_r;
  assign hresp       = 1'b0;
  assign sample_hold = sample_hold_r;
  assign conv_start  = conv_start_r;
  assign interrupt   = interrupt_r;

  property p_stopirq;
    @(posedge clock) disable iff (!reset_n)
    auto_stop && !wr_ctrl |=> !autostart_r && !sample_hold_r;
  endproperty
  a_stopirq: assert property (p_stopirq) else $error("auto-start not cleared"); // [RULE1]

  property p_overwrite;
    @(posedge clock) disable iff (!reset_n)
    cmpl |=> result_r == $past(conv_result);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("result not stored"); // [RULE2]

  property p_autosample;
    @(posedge clock) disable iff (!reset_n)
    cmpl && autostart_r && !stopirq_r && on_r && !wr_ctrl |=> sample_hold_r && in_sample;
  endproperty
  a_autosample: assert property (p_autosample) else $error("no auto resample"); // [RULE3]

  property p_swstart;
    @(posedge clock) disable iff (!reset_n)
    on_r && state_r == ADCSC_ST_IDLE && sw_start |=> sample_hold_r ##1 sample_hold_r;
  endproperty
  a_swstart: assert property (p_swstart) else $error("software start ignored"); // [RULE4]

  property p_swend;
    @(posedge clock) disable iff (!reset_n)
    on_r && in_sample && sw_end |=> conv_start_r && in_convert && !sample_hold_r;
  endproperty
  a_swend: assert property (p_swend) else $error("software end ignored"); // [RULE5]

  property p_hwend;
    @(posedge clock) disable iff (!reset_n)
    in_sample && trigsrc_r != ADCSC_TRIG_SW && !hw_end && !wr_ctrl |=> !conv_start_r;
  endproperty
  a_hwend: assert property (p_hwend) else $error("conversion without trigger"); // [RULE6]

  property p_flag;
    @(posedge clock) disable iff (!reset_n)
    sample_hold_r == in_sample;
  endproperty
  a_flag: assert property (p_flag) else $error("sample flag wrong"); // [RULE7]

  property p_done_set;
    @(posedge clock) disable iff (!reset_n)
    cmpl |=> done_r && irq_stat_r[ADCSC_IRQ_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done or event missing"); // [RULE8]

  property p_done_one;
    @(posedge clock) disable iff (!reset_n)
    !done_r && !cmpl && wr_ctrl |=> !done_r;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done set by software"); // [RULE9]

  property p_done_clr;
    @(posedge clock) disable iff (!reset_n)
    conv_start_r |-> !done_r;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done kept at start"); // [RULE10]

endmodule : adcsc_top

`default_nettype wire

// ===== adcsc_core_model.sv
`timescale 1ns/10ps
`default_nettype none

module adcsc_core_model
  import adcsc_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire logic                   conv_start,
  input  wire logic [7:0]             dly,
  input  wire logic [ADCSC_RES_W-1:0] res_in,
  output logic                        conv_complete,
  output logic      [ADCSC_RES_W-1:0] conv_result
);
  logic [ADCSC_RES_W-1:0] held_r;
  logic [8:0]             cnt_r;
  logic                   tog_r;

  // Done pulse lasts 8 cycles so the result outlives the input synchroniser
  assign conv_complete = (cnt_r != 9'h000) && (cnt_r <= 9'h008);
  // Off the hold window the bus changes every cycle, so a stale read matches only on alternate cycles
  assign conv_result   = conv_complete ? held_r : (held_r ^ {ADCSC_RES_W{tog_r}});

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r  <= 9'h000;
      held_r <= '0;
      tog_r  <= 1'h0;
    end
    else
    begin
      tog_r <= ~tog_r;
      if (conv_start)
      begin
        cnt_r  <= {1'h0, dly} + 9'h008;
        held_r <= res_in;
      end
      else if (cnt_r != 9'h000)
        cnt_r <= cnt_r - 9'h001;
    end
  end
endmodule : adcsc_core_model

`default_nettype wire

// ===== adcsc_tb.sv
`timescale 1ns/10ps
`default_nettype none

module adcsc_tb;
  import adcsc_pkg::*;
  logic                   clock, reset_n, hsel, hwrite, trigger_pin, hready, hresp;
  logic                   conv_start, conv_complete, sample_hold, interrupt;
  logic [1:0]             htrans;
  logic [31:0]            haddr, hwdata, hrdata, q;
  logic [7:0]             dly;
  logic [ADCSC_RES_W-1:0] res_in, conv_result;
  int                     mismatches, total_checks, seed;

  adcsc_top i_adcsc_top (
    .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .trigger_pin(trigger_pin),
    .conv_complete(conv_complete), .conv_result(conv_result),
    .sample_hold(sample_hold), .conv_start(conv_start), .interrupt(interrupt));

  adcsc_core_model i_adcsc_core_model (
    .clock(clock), .reset_n(reset_n), .conv_start(conv_start), .dly(dly),
    .res_in(res_in), .conv_complete(conv_complete), .conv_result(conv_result));

  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do @(posedge clock); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'h1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(q, e);
  endtask : rd

  // Bounded wait on start pulse (k=1) or interrupt (k=0)
  task automatic wt(input logic k);
    int n;
    n = 0;
    while (((k ? conv_start : interrupt) !== 1'h1) && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    chk(32'(n < 3000), 32'h1);
  endtask : wt

  task automatic settle(input logic v);
    repeat (2) @(posedge clock);
    chk(32'(interrupt), 32'(v));
  endtask : settle

  task automatic new_res;
    res_in <= ADCSC_RES_W'($random(seed));
    dly    <= 8'h08 + {4'h0, 4'($random(seed))};
  endtask : new_res

  // Flags are {stop option, auto start, sample, done}
  function automatic logic [31:0] cw(input logic [2:0] s, input logic [3:0] f);
    cw = 32'h0;
    cw[ADCSC_BIT_ON] = 1'h1;
    cw[ADCSC_TRIGSRC_LO +: ADCSC_TRIGSRC_W] = s;
    cw[ADCSC_BIT_STOPIRQ] = f[3];
    cw[ADCSC_BIT_AUTOSTART] = f[2];
    cw[ADCSC_BIT_SAMPLING] = f[1];
    cw[ADCSC_BIT_DONE] = f[0];
  endfunction : cw

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    test_done;
  end

  initial
  begin
    seed = 94;
    {mismatches, total_checks, haddr, hwdata} = '0;
    {reset_n, hsel, htrans, hwrite, trigger_pin, dly, res_in} = '0;
    repeat (8) @(posedge clock);
    reset_n <= 1'h1;
    rd(ADCSC_ADDR_CTRL, ADCSC_RESET_WORD);
    rd(8'h14, 32'h0);
    chk(32'(hresp), 32'h0);
    wr(ADCSC_ADDR_ENA, 32'h3);
    new_res;
    // Sample command acts on the old on bit, so switch on first
    wr(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_SW, 4'h0));
    wr(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_SW, 4'h2));
    repeat (2) @(posedge clock);
    chk(32'(sample_hold), 32'h1);
    rd(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_SW, 4'h2));
    wr(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_SW, 4'h0));
    wt(1'h1);
    wt(1'h0);
    chk(32'(sample_hold), 32'h0);
    rd(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_SW, 4'h1));
    rd(ADCSC_ADDR_RESULT, 32'(res_in));
    rd(ADCSC_ADDR_STAT, 32'h1);
    wr(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_SW, 4'h0));
    rd(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_SW, 4'h0));
    wr(ADCSC_ADDR_CLR, 32'h3);
    settle(1'h0);
    new_res;
    wr(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_PIN, 4'h2));
    repeat (5 + ($unsigned($random(seed)) % 20)) @(posedge clock);
    rd(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_PIN, 4'h2));
    trigger_pin <= 1'h1;
    wt(1'h1);
    trigger_pin <= 1'h0;
    wt(1'h0);
    rd(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_PIN, 4'h1));
    rd(ADCSC_ADDR_RESULT, 32'(res_in));
    wr(ADCSC_ADDR_CLR, 32'h3);
    new_res;
    wr(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_AUTO, 4'h6));
    wt(1'h0);
    rd(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_AUTO, 4'h7));
    chk(32'(sample_hold), 32'h1);
    rd(ADCSC_ADDR_RESULT, 32'(res_in));
    new_res;
    wr(ADCSC_ADDR_CLR, 32'h3);
    wt(1'h1);
    rd(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_AUTO, 4'h4));
    wr(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_AUTO, 4'h4));
    wt(1'h0);
    rd(ADCSC_ADDR_RESULT, 32'(res_in));
    wr(ADCSC_ADDR_CTRL, 32'h0);
    @(posedge clock);
    wr(ADCSC_ADDR_CLR, 32'h3);
    new_res;
    // Auto start with stop option: hardware must drop auto start itself
    wr(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_AUTO, 4'hC));
    wt(1'h0);
    rd(ADCSC_ADDR_CTRL, cw(ADCSC_TRIG_AUTO, 4'h9));
    rd(ADCSC_ADDR_STAT, 32'h3);
    repeat (150) @(posedge clock);
    chk(32'(sample_hold), 32'h0);
    wr(ADCSC_ADDR_ENA, 32'h0);
    settle(1'h0);
    wr(ADCSC_ADDR_ENA, 32'h2);
    settle(1'h1);
    wr(ADCSC_ADDR_CLR, 32'h2);
    settle(1'h0);
    rd(ADCSC_ADDR_STAT, 32'h1);
    test_done;
  end
endmodule : adcsc_tb

`default_nettype wire
